// ---- design/rtcs_defs.svh ----
// constant names of the serial clock calendar
`ifndef RTCS_DEFS_SVH
`define RTCS_DEFS_SVH
`define RTCS_SLAVE_ADDR 7'h68
`define RTCS_NREG 5'h14
`define RTCS_NCLK 5'h08
`define RTCS_A_FLAGS 5'h0F
`define RTCS_A_RSV_LO 5'h10
`define RTCS_A_RSV_HI 5'h12
`define RTCS_T_HUND 3'h0
`define RTCS_T_SEC 3'h1
`define RTCS_T_MIN 3'h2
`define RTCS_T_HOUR 3'h3
`define RTCS_T_DAY 3'h4
`define RTCS_T_DATE 3'h5
`define RTCS_T_MON 3'h6
`define RTCS_T_YEAR 3'h7
`define RTCS_M_CTRL 4'h0
`define RTCS_M_F32 4'h1
`define RTCS_M_AMON 4'h2
`define RTCS_M_ADATE 4'h3
`define RTCS_M_AHOUR 4'h4
`define RTCS_M_AMIN 4'h5
`define RTCS_M_ASEC 4'h6
`define RTCS_M_FLAGS 4'h7
`define RTCS_M_SQW 4'hB
`define RTCS_B_CEB 7
`define RTCS_B_CB 6
`define RTCS_B_OUT 7
`define RTCS_B_F32E 7
`define RTCS_B_AFE 7
`define RTCS_B_SQWE 6
`define RTCS_B_AF 6
`define RTCS_RS_MSB 7
`define RTCS_RS_LSB 4
`define RTCS_RST_CTRL 8'h80
`define RTCS_RST_F32 8'h80
`define RTCS_RST_CAL 8'h01
`define RTCS_HUND_MAX 8'h99
`define RTCS_MS_MAX 8'h59
`define RTCS_HOUR_MAX 8'h23
`define RTCS_DAY_MAX 8'h07
`define RTCS_DATE_MAX 8'h31
`define RTCS_MON_MAX 8'h12
`define RTCS_YEAR_MAX 8'h99
`define RTCS_CAL_MIN 8'h01
`define RTCS_OSC_HZ 32768
`define RTCS_TICK_HZ 100
`define RTCS_PSC_W 15
`define RTCS_BYTE_BITS 4'h8
`endif

// ---- design/rtcs_osc_tick.sv ----
// oscillator domain: hundredths tick by fractional accumulation
`timescale 1ns/1ps
`default_nettype none
`include "rtcs_defs.svh"
module rtcs_osc_tick
   import rtcs_pkg::*;
#(
   parameter int OSC_HZ = `RTCS_OSC_HZ,
   parameter int TICK_HZ = `RTCS_TICK_HZ
) (
   input wire logic osc_clk_in,
   input wire logic rst_n_in,
   rtcs_tick_if.src tick_if
);
   localparam logic [`RTCS_PSC_W:0] STEP = (`RTCS_PSC_W+1)'(TICK_HZ);
   rtcs_osc_t c_r;
   rtcs_osc_t c_nxt;
   logic [`RTCS_PSC_W:0] sum;

   if (OSC_HZ != 2 ** `RTCS_PSC_W || TICK_HZ < 1 || TICK_HZ >= OSC_HZ)
   begin : g_bad
      $error("unsupported oscillator or tick rate");
   end

   always_comb begin
      c_nxt = c_r;
      sum = {1'b0, c_r.acc} + STEP;
      c_nxt.acc = sum[`RTCS_PSC_W-1:0];
      if (sum[`RTCS_PSC_W]) begin
         c_nxt.tgl = ~c_r.tgl;
      end
   end

   always_ff @(posedge osc_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         c_r <= '0;
      end else begin
         c_r <= c_nxt;
      end
   end

   assign tick_if.tgl = c_r.tgl;
endmodule // rtcs_osc_tick
`default_nettype wire

// ---- design/rtcs_pkg.sv ----
// types of the serial clock calendar
`include "rtcs_defs.svh"
package rtcs_pkg;
   typedef enum logic [2:0] {
      ST_IDLE, ST_DEV, ST_DACK, ST_RX, ST_RACK, ST_TX, ST_MACK
   } rtcs_state_t;
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic q;
   } rtcs_sync_t;
   typedef struct packed {
      logic [`RTCS_PSC_W-1:0] acc;
      logic tgl;
   } rtcs_osc_t;
   typedef struct packed {
      rtcs_state_t st;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic rw;
      logic first;
      logic ack;
      logic [4:0] ptr;
      logic sda_oe;
      logic frz;
      logic scl_d;
      logic sda_d;
      logic osc_d;
      logic tick_d;
      logic [7:0][7:0] tm;
      logic [7:0][7:0] usr;
      logic [11:0][7:0] mr;
      logic [`RTCS_PSC_W-1:0] psc;
      logic wave_oe;
      logic f32_oe;
      logic zero;
   } rtcs_core_t;
endpackage

// ---- design/rtcs_sync3.sv ----
// three stage synchroniser, level taken when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module rtcs_sync3
   import rtcs_pkg::*;
#(
   parameter logic RST_VAL = 1'b0
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic d_in,
   output logic q_out
);
   rtcs_sync_t c_r;
   rtcs_sync_t c_nxt;

   always_comb begin
      c_nxt = c_r;
      c_nxt.s1 = d_in;
      c_nxt.s2 = c_r.s1;
      c_nxt.s3 = c_r.s2;
      if (c_r.s2 == c_r.s3) begin
         c_nxt.q = c_r.s3;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         c_r <= {4{RST_VAL}};
      end else if (ce_in) begin
         c_r <= c_nxt;
      end
   end

   assign q_out = c_r.q;
endmodule // rtcs_sync3
`default_nettype wire

// ---- design/rtcs_tick_if.sv ----
// hundredths tick toggle passed out of the oscillator domain
`timescale 1ns/1ps
`default_nettype none
interface rtcs_tick_if;
   logic tgl;
   modport src (output tgl);
   modport dst (input tgl);
endinterface
`default_nettype wire

// ---- design/rtcs_top.sv ----
// serial clock calendar with alarm, square wave and two-wire slave
`timescale 1ns/1ps
`default_nettype none
`include "rtcs_defs.svh"
module rtcs_top
   import rtcs_pkg::*;
(
   input wire logic CLK_IN,
   input wire logic RST_N_IN,
   input wire logic CE_IN,
   input wire logic OSCILLATOR_IN_PIN_IN,
   input wire logic SCL_IN,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE_OUT,
   output logic SHARED_IRQ_OUTPUT_WAVE_PIN_OUT,
   output logic SHARED_IRQ_OUTPUT_WAVE_PIN_OE_OUT,
   output logic DEDICATED_32KHZ_OUTPUT_OUT,
   output logic DEDICATED_32KHZ_OUTPUT_OE_OUT
);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [8:0] bcd_inc(input logic [7:0] v,
         input logic [7:0] hi, input logic [7:0] lo);
      if (v >= hi) begin
         return {1'b1, lo};
      end
      if (v[3:0] == 4'h9) begin
         return {1'b0, v[7:4] + 4'h1, 4'h0};
      end
      return {1'b0, v + 8'h01};
   endfunction

   function automatic logic [7:0] last_date(input logic [7:0] mon,
         input logic [7:0] yr);
      logic leap;
      leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                   : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4
                      || yr[3:0] == 4'h8);
      case (mon)
         8'h02: last_date = leap ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: last_date = 8'h30;
         default: last_date = 8'h31;
      endcase
   endfunction

   function automatic logic [4:0] ptr_inc(input logic [4:0] p);
      return (p == `RTCS_NREG - 5'h01) ? 5'h00 : p + 5'h01;
   endfunction

   // ------------------------------------------------------------
   // crossings
   // ------------------------------------------------------------
   rtcs_tick_if tick_bus ();
   logic scl;
   logic sda;
   logic oq;
   logic tq;

   rtcs_osc_tick #(
      .OSC_HZ(`RTCS_OSC_HZ),
      .TICK_HZ(`RTCS_TICK_HZ)
   ) u_osc (
      .osc_clk_in(OSCILLATOR_IN_PIN_IN),
      .rst_n_in(RST_N_IN),
      .tick_if(tick_bus)
   );

   rtcs_sync3 #(.RST_VAL(1'b1)) u_scl (
      .clk_in(CLK_IN),
      .rst_n_in(RST_N_IN),
      .ce_in(CE_IN),
      .d_in(SCL_IN),
      .q_out(scl)
   );
   rtcs_sync3 #(.RST_VAL(1'b1)) u_sda (
      .clk_in(CLK_IN),
      .rst_n_in(RST_N_IN),
      .ce_in(CE_IN),
      .d_in(SDA_IN),
      .q_out(sda)
   );
   rtcs_sync3 #(.RST_VAL(1'b0)) u_oscl (
      .clk_in(CLK_IN),
      .rst_n_in(RST_N_IN),
      .ce_in(CE_IN),
      .d_in(OSCILLATOR_IN_PIN_IN),
      .q_out(oq)
   );
   rtcs_sync3 #(.RST_VAL(1'b0)) u_tick (
      .clk_in(CLK_IN),
      .rst_n_in(RST_N_IN),
      .ce_in(CE_IN),
      .d_in(tick_bus.tgl),
      .q_out(tq)
   );

   // ------------------------------------------------------------
   // state and bus events
   // ------------------------------------------------------------
   rtcs_core_t c_r;
   rtcs_core_t c_nxt;
   logic scl_rise;
   logic scl_fall;
   logic start;
   logic stop;
   logic tick;
   logic ld;
   logic wr;
   logic wr_clk;
   logic cy;
   logic hc;
   logic irq;
   logic wv;
   logic wave_on;
   logic [8:0] r;
   logic [7:0] rdv;
   logic [4:0] ridx;
   logic [3:0] rs;

   assign scl_rise = scl && !c_r.scl_d;
   assign scl_fall = !scl && c_r.scl_d;
   assign start = scl && c_r.scl_d && c_r.sda_d && !sda;
   assign stop = scl && c_r.scl_d && !c_r.sda_d && sda;
   assign tick = tq ^ c_r.tick_d;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      c_nxt = c_r;
      ld = 1'b0;
      wr = 1'b0;
      cy = 1'b0;
      hc = 1'b0;
      r = '0;
      wv = 1'b0;
      c_nxt.scl_d = scl;
      c_nxt.sda_d = sda;
      c_nxt.osc_d = oq;
      c_nxt.tick_d = tq;
      c_nxt.zero = 1'b0;
      ridx = c_r.ptr - `RTCS_NCLK;
      if (c_r.ptr < `RTCS_NCLK) begin
         rdv = c_r.usr[c_r.ptr[2:0]];
      end else if (c_r.ptr >= `RTCS_A_RSV_LO
                   && c_r.ptr <= `RTCS_A_RSV_HI) begin
         rdv = 8'h00;
      end else begin
         rdv = c_r.mr[ridx[3:0]];
      end
      if (stop) begin
         c_nxt.st = ST_IDLE;
         c_nxt.sda_oe = 1'b0;
      end else if (start) begin
         c_nxt.st = ST_DEV;
         c_nxt.cnt = 4'h0;
         c_nxt.sda_oe = 1'b0;
      end else begin
         case (c_r.st)
            ST_DEV, ST_RX: begin
               if (scl_rise) begin
                  c_nxt.sh = {c_r.sh[6:0], sda};
                  c_nxt.cnt = c_r.cnt + 4'h1;
               end
               if (scl_fall && c_r.cnt == `RTCS_BYTE_BITS) begin
                  c_nxt.cnt = 4'h0;
                  if (c_r.st == ST_DEV) begin
                     if (c_r.sh[7:1] == `RTCS_SLAVE_ADDR) begin
                        c_nxt.rw = c_r.sh[0];
                        c_nxt.first = !c_r.sh[0];
                        c_nxt.st = ST_DACK;
                        c_nxt.sda_oe = 1'b1;
                     end else begin
                        c_nxt.st = ST_IDLE;
                     end
                  end else begin
                     c_nxt.st = ST_RACK;
                     c_nxt.sda_oe = 1'b1;
                     if (c_r.first) begin
                        c_nxt.first = 1'b0;
                        c_nxt.ptr = (c_r.sh < {3'h0, `RTCS_NREG})
                                    ? c_r.sh[4:0] : 5'h00;
                     end else begin
                        wr = 1'b1;
                        c_nxt.ptr = ptr_inc(c_r.ptr);
                     end
                  end
               end
            end
            ST_DACK, ST_RACK: begin
               if (scl_fall) begin
                  if (c_r.st == ST_DACK && c_r.rw) begin
                     ld = 1'b1;
                  end else begin
                     c_nxt.sda_oe = 1'b0;
                     c_nxt.st = ST_RX;
                  end
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  if (c_r.cnt == `RTCS_BYTE_BITS) begin
                     c_nxt.sda_oe = 1'b0;
                     c_nxt.st = ST_MACK;
                  end else begin
                     c_nxt.sh = {c_r.sh[6:0], 1'b0};
                     c_nxt.sda_oe = !c_r.sh[6];
                     c_nxt.cnt = c_r.cnt + 4'h1;
                  end
               end
            end
            ST_MACK: begin
               if (scl_rise) begin
                  c_nxt.ack = !sda;
                  c_nxt.ptr = ptr_inc(c_r.ptr);
               end
               if (scl_fall) begin
                  if (c_r.ack) begin
                     ld = 1'b1;
                  end else begin
                     c_nxt.st = ST_IDLE;
                  end
               end
            end
            default: begin
               c_nxt.sda_oe = 1'b0;
            end
         endcase
      end
      if (ld) begin
         c_nxt.sh = rdv;
         c_nxt.sda_oe = !rdv[7];
         c_nxt.cnt = 4'h1;
         c_nxt.st = ST_TX;
         if (c_r.ptr == `RTCS_A_FLAGS) begin
            c_nxt.mr[`RTCS_M_FLAGS][`RTCS_B_AF] = 1'b0;
         end
      end
      if (wr && c_r.ptr < `RTCS_NCLK) begin
         c_nxt.tm[c_r.ptr[2:0]] = c_r.sh;
         c_nxt.usr[c_r.ptr[2:0]] = c_r.sh;
      end else if (wr && !(c_r.ptr >= `RTCS_A_RSV_LO
                           && c_r.ptr <= `RTCS_A_RSV_HI)) begin
         c_nxt.mr[ridx[3:0]] = c_r.sh;
      end
      if (tick && !(wr && c_r.ptr < `RTCS_NCLK)) begin
         r = bcd_inc(c_r.tm[`RTCS_T_HUND], `RTCS_HUND_MAX, 8'h00);
         c_nxt.tm[`RTCS_T_HUND] = r[7:0];
         cy = r[8];
         if (cy) begin
            r = bcd_inc(c_r.tm[`RTCS_T_SEC], `RTCS_MS_MAX, 8'h00);
            c_nxt.tm[`RTCS_T_SEC] = r[7:0];
            cy = r[8];
         end
         if (cy) begin
            r = bcd_inc(c_r.tm[`RTCS_T_MIN], `RTCS_MS_MAX, 8'h00);
            c_nxt.tm[`RTCS_T_MIN] = r[7:0];
            cy = r[8];
         end
         if (cy) begin
            r = bcd_inc({2'b00, c_r.tm[`RTCS_T_HOUR][5:0]},
                        `RTCS_HOUR_MAX, 8'h00);
            c_nxt.tm[`RTCS_T_HOUR][5:0] = r[5:0];
            cy = r[8];
            hc = r[8];
         end
         if (hc) begin
            r = bcd_inc(c_r.tm[`RTCS_T_DAY], `RTCS_DAY_MAX,
                        `RTCS_CAL_MIN);
            c_nxt.tm[`RTCS_T_DAY] = r[7:0];
            r = bcd_inc(c_r.tm[`RTCS_T_DATE],
                        last_date(c_r.tm[`RTCS_T_MON],
                                  c_r.tm[`RTCS_T_YEAR]),
                        `RTCS_CAL_MIN);
            c_nxt.tm[`RTCS_T_DATE] = r[7:0];
            cy = r[8];
         end
         if (cy) begin
            r = bcd_inc(c_r.tm[`RTCS_T_MON], `RTCS_MON_MAX,
                        `RTCS_CAL_MIN);
            c_nxt.tm[`RTCS_T_MON] = r[7:0];
            cy = r[8];
         end
         if (cy) begin
            r = bcd_inc(c_r.tm[`RTCS_T_YEAR], `RTCS_YEAR_MAX, 8'h00);
            c_nxt.tm[`RTCS_T_YEAR] = r[7:0];
            cy = r[8];
         end
         if (cy && c_r.tm[`RTCS_T_HOUR][`RTCS_B_CEB]) begin
            c_nxt.tm[`RTCS_T_HOUR][`RTCS_B_CB] =
               !c_r.tm[`RTCS_T_HOUR][`RTCS_B_CB];
         end
         if (c_nxt.tm[`RTCS_T_HUND] == 8'h00
             && c_nxt.tm[`RTCS_T_SEC][6:0]
                == c_r.mr[`RTCS_M_ASEC][6:0]
             && c_nxt.tm[`RTCS_T_MIN][6:0]
                == c_r.mr[`RTCS_M_AMIN][6:0]
             && c_nxt.tm[`RTCS_T_HOUR][5:0]
                == c_r.mr[`RTCS_M_AHOUR][5:0]
             && c_nxt.tm[`RTCS_T_DATE][5:0]
                == c_r.mr[`RTCS_M_ADATE][5:0]
             && c_nxt.tm[`RTCS_T_MON][4:0]
                == c_r.mr[`RTCS_M_AMON][4:0]) begin
            c_nxt.mr[`RTCS_M_FLAGS][`RTCS_B_AF] = 1'b1;
         end
      end
      // user copy frozen while a transfer is active (state not idle) and pointer below 08h
      c_nxt.frz = (c_nxt.st != ST_IDLE) && (c_nxt.ptr < `RTCS_NCLK);
      if (!c_nxt.frz) begin
         c_nxt.usr = c_nxt.tm;
      end
      if (oq && !c_r.osc_d) begin
         c_nxt.psc = c_r.psc + `RTCS_PSC_W'(1);
      end
      rs = c_r.mr[`RTCS_M_SQW][`RTCS_RS_MSB:`RTCS_RS_LSB];
      if (rs == 4'h1) begin
         wv = oq;
      end else if (rs != 4'h0) begin
         wv = c_r.psc[rs - 4'h1];
      end
      wave_on = c_r.mr[`RTCS_M_AMON][`RTCS_B_SQWE] && rs != 4'h0;
      irq = c_r.mr[`RTCS_M_AMON][`RTCS_B_AFE]
            && c_r.mr[`RTCS_M_FLAGS][`RTCS_B_AF];
      if (irq) begin
         c_nxt.wave_oe = 1'b1;
      end else if (wave_on) begin
         c_nxt.wave_oe = !wv;
      end else begin
         c_nxt.wave_oe = !c_r.mr[`RTCS_M_CTRL][`RTCS_B_OUT];
      end
      c_nxt.f32_oe = c_r.mr[`RTCS_M_F32][`RTCS_B_F32E] && !oq;
   end

   assign wr_clk = wr && c_r.ptr < `RTCS_NCLK;

   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         c_r <= '0;
         c_r.scl_d <= 1'b1;
         c_r.sda_d <= 1'b1;
         c_r.tm[`RTCS_T_DAY] <= `RTCS_RST_CAL;
         c_r.tm[`RTCS_T_DATE] <= `RTCS_RST_CAL;
         c_r.tm[`RTCS_T_MON] <= `RTCS_RST_CAL;
         c_r.usr[`RTCS_T_DAY] <= `RTCS_RST_CAL;
         c_r.usr[`RTCS_T_DATE] <= `RTCS_RST_CAL;
         c_r.usr[`RTCS_T_MON] <= `RTCS_RST_CAL;
         c_r.mr[`RTCS_M_CTRL] <= `RTCS_RST_CTRL;
         c_r.mr[`RTCS_M_F32] <= `RTCS_RST_F32;
      end else if (CE_IN) begin
         c_r <= c_nxt;
      end
   end

   assign SDA_OUT = c_r.zero;
   assign SDA_OE_OUT = c_r.sda_oe;
   assign SHARED_IRQ_OUTPUT_WAVE_PIN_OUT = c_r.zero;
   assign SHARED_IRQ_OUTPUT_WAVE_PIN_OE_OUT = c_r.wave_oe;
   assign DEDICATED_32KHZ_OUTPUT_OUT = c_r.zero;
   assign DEDICATED_32KHZ_OUTPUT_OE_OUT = c_r.f32_oe;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!RST_N_IN);

   sequence s_own_addr;
      CE_IN && c_r.st == ST_DEV && c_r.cnt == `RTCS_BYTE_BITS
      && scl_fall && !start && !stop;
   endsequence

   chk_hour_range: assert property (
      c_r.tm[`RTCS_T_HOUR][5:0] <= `RTCS_HOUR_MAX)
      else $error("hour beyond 23");
   chk_date_range: assert property (
      c_r.tm[`RTCS_T_DATE] <= `RTCS_DATE_MAX
      && c_r.tm[`RTCS_T_DATE] >= `RTCS_CAL_MIN)
      else $error("date out of range");
   chk_hund_carry: assert property (
      CE_IN && tick && !wr_clk
      && c_r.tm[`RTCS_T_HUND] == `RTCS_HUND_MAX
      |=> c_r.tm[`RTCS_T_HUND] == 8'h00
      && c_r.tm[`RTCS_T_SEC] != $past(c_r.tm[`RTCS_T_SEC]))
      else $error("hundredths carry lost");
   chk_addr_ack: assert property (
      s_own_addr ##0 c_r.sh[7:1] == `RTCS_SLAVE_ADDR
      |=> SDA_OE_OUT && c_r.st == ST_DACK)
      else $error("own address not acknowledged");
   chk_addr_ignore: assert property (
      s_own_addr ##0 c_r.sh[7:1] != `RTCS_SLAVE_ADDR
      |=> !SDA_OE_OUT && c_r.st == ST_IDLE)
      else $error("foreign address answered");
   chk_ptr_ack_clk: assert property (
      CE_IN && c_r.st == ST_MACK && scl_rise && !start && !stop
      |=> c_r.ptr == ptr_inc($past(c_r.ptr)))
      else $error("pointer missed acknowledge step");
   chk_copy_frozen: assert property (
      CE_IN && c_r.frz && c_nxt.frz && !wr_clk
      |=> c_r.usr == $past(c_r.usr))
      else $error("user copy moved while frozen");
   chk_stop_thaw: assert property (
      CE_IN && stop |=> !c_r.frz ##1 !CE_IN || c_r.usr == c_r.tm)
      else $error("copy not resumed after stop");
endmodule // rtcs_top
`default_nettype wire

// ---- testbench/rtcs_mst.sv ----
// two-wire bus master model facing the clock calendar
`timescale 1ns/1ps
`default_nettype none
module rtcs_mst (
   input wire logic clk_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_oe_out
);
   localparam int HALF = 12;
   initial begin
      scl_out = 1'h1;
      sda_oe_out = 1'h0;
   end
   task automatic wt(input int n);
      repeat (n) @(negedge clk_in);
   endtask
   task automatic start();
      wt(2);
      sda_oe_out = 1'h0;
      wt(HALF);
      scl_out = 1'h1;
      wt(HALF);
      sda_oe_out = 1'h1;
      wt(HALF);
      scl_out = 1'h0;
   endtask
   task automatic stop();
      wt(2);
      sda_oe_out = 1'h1;
      wt(HALF);
      scl_out = 1'h1;
      wt(HALF);
      sda_oe_out = 1'h0;
      wt(HALF);
   endtask
   task automatic bit_io(input logic b, output logic r);
      wt(2);
      sda_oe_out = ~b;
      wt(HALF);
      scl_out = 1'h1;
      wt(HALF);
      r = sda_in;
      scl_out = 1'h0;
   endtask
   task automatic wr(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
      end
      bit_io(1'h1, r);
      ack = ~r;
   endtask
   task automatic rd(input logic nack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'h1, r);
         d[i] = r;
      end
      bit_io(nack, r);
   endtask
endmodule // rtcs_mst
`default_nettype wire

// ---- testbench/tb_rtcs_top.sv ----
// self-checking bench for the serial clock calendar
`timescale 1ns/1ps
`default_nettype none
module tb_rtcs_top;
   logic clk = 1'h0;
   logic osc = 1'h0;
   logic rst_n = 1'h0;
   logic ce = 1'h1;
   logic scl, sda_oe_m, sda_oe_d, sda_o, irq_o, irq_oe, f32_o, f32_oe;
   wire sda;
   int n_fail = 0;
   int checks = 0;
   int n_f32 = 0;
   int n_irq = 0;
   logic [7:0] buf_q [8];
   logic [7:0] exp_q [8];
   // pull-up on the data wire
   assign sda = ~(sda_oe_m | sda_oe_d);
   always #2.5 clk = ~clk;
   always #24 osc = ~osc;
   always @(f32_oe) n_f32++;
   always @(irq_oe) n_irq++;
   rtcs_top i_dut (.CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(ce),
      .OSCILLATOR_IN_PIN_IN(osc), .SCL_IN(scl), .SDA_IN(sda),
      .SDA_OUT(sda_o), .SDA_OE_OUT(sda_oe_d),
      .SHARED_IRQ_OUTPUT_WAVE_PIN_OUT(irq_o),
      .SHARED_IRQ_OUTPUT_WAVE_PIN_OE_OUT(irq_oe),
      .DEDICATED_32KHZ_OUTPUT_OUT(f32_o),
      .DEDICATED_32KHZ_OUTPUT_OE_OUT(f32_oe));
   rtcs_mst i_mst (.clk_in(clk), .sda_in(sda), .scl_out(scl),
      .sda_oe_out(sda_oe_m));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic cmp(input int n);
      for (int i = 0; i < n; i++) begin
         check(buf_q[i], exp_q[i]);
      end
   endtask
   task automatic wr_regs(input logic [7:0] a, input int n);
      logic ack;
      i_mst.start();
      i_mst.wr(8'hD0, ack);
      check({7'h00, ack}, 8'h01);
      i_mst.wr(a, ack);
      for (int i = 0; i < n; i++) begin
         i_mst.wr(buf_q[i], ack);
         check({7'h00, ack}, 8'h01);
      end
      i_mst.stop();
   endtask
   task automatic rd_regs(input logic [7:0] a, input int n);
      logic ack;
      i_mst.start();
      i_mst.wr(8'hD0, ack);
      i_mst.wr(a, ack);
      i_mst.start();
      i_mst.wr(8'hD1, ack);
      for (int i = 0; i < n; i++) begin
         i_mst.rd(i == n - 1, buf_q[i]);
      end
      i_mst.stop();
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset();
      rd_regs(8'h03, 7);
      exp_q = '{8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h80, 8'h80, 8'h00};
      cmp(7);
      check({7'h00, irq_oe}, 8'h00);
   endtask
   task automatic t_regs();
      buf_q = '{8'h21, 8'h45, 8'h30, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      wr_regs(8'h0C, 3);
      rd_regs(8'h0C, 3);
      exp_q = '{8'h21, 8'h45, 8'h30, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      cmp(3);
      buf_q[0] = 8'hA5;
      wr_regs(8'h10, 1);
      rd_regs(8'h10, 1);
      check(buf_q[0], 8'h00);
   endtask
   task automatic t_badaddr();
      logic ack;
      i_mst.start();
      i_mst.wr(8'hA0, ack);
      i_mst.stop();
      check({7'h00, ack}, 8'h00);
   endtask
   task automatic t_pins();
      int n0;
      n0 = n_f32;
      repeat (200) @(negedge clk);
      check({7'h00, n_f32 > n0 + 5}, 8'h01);
      check({5'h00, sda_o, irq_o, f32_o}, 8'h00);
      ce = 1'h0;
      n0 = n_f32;
      repeat (200) @(negedge clk);
      check({7'h00, n_f32 == n0}, 8'h01);
      ce = 1'h1;
      buf_q[0] = 8'h40;
      wr_regs(8'h0A, 1);
      buf_q[0] = 8'h10;
      wr_regs(8'h13, 1);
      n0 = n_irq;
      repeat (200) @(negedge clk);
      check({7'h00, n_irq > n0 + 5}, 8'h01);
      buf_q[0] = 8'h20;
      wr_regs(8'h13, 1);
      n0 = n_irq;
      repeat (400) @(negedge clk);
      check({7'h00, n_irq > n0 + 5 && n_irq < n0 + 30}, 8'h01);
      buf_q[0] = 8'h00;
      wr_regs(8'h13, 1);
      wr_regs(8'h0A, 1);
      wr_regs(8'h08, 1);
      check({7'h00, irq_oe}, 8'h01);
      buf_q[0] = 8'h80;
      wr_regs(8'h08, 1);
      check({7'h00, irq_oe}, 8'h00);
   endtask
   task automatic t_roll(input logic [7:0] hr, dt, mo, yr,
                         input logic [7:0] e_hr, e_dt, e_mo, e_yr,
                         input logic alm);
      buf_q = '{8'h81, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      if (alm) begin
         wr_regs(8'h0A, 5);
      end
      buf_q = '{8'h00, 8'h59, 8'h59, hr, 8'h07, dt, mo, yr};
      wr_regs(8'h00, 8);
      buf_q[0] = 8'h99;
      wr_regs(8'h00, 1);
      repeat (4000) @(negedge clk);
      rd_regs(8'h01, 7);
      exp_q = '{8'h00, 8'h00, e_hr, 8'h01, e_dt, e_mo, e_yr, 8'h00};
      cmp(7);
      check({7'h00, irq_oe}, {7'h00, alm});
      if (alm) begin
         rd_regs(8'h0F, 1);
         check(buf_q[0], 8'h40);
         check({7'h00, irq_oe}, 8'h00);
         buf_q[0] = 8'h00;
         wr_regs(8'h0A, 1);
      end
   endtask
   initial begin
      repeat (12) @(negedge clk);
      rst_n = 1'h1;
      repeat (10) @(negedge clk);
      t_reset();
      t_regs();
      t_badaddr();
      t_pins();
      t_roll(8'hA3, 8'h31, 8'h12, 8'h99, 8'hC0, 8'h01, 8'h01, 8'h00, 1'h1);
      t_roll(8'h23, 8'h28, 8'h02, 8'h00, 8'h00, 8'h29, 8'h02, 8'h00, 1'h0);
      t_roll(8'h23, 8'h28, 8'h02, 8'h01, 8'h00, 8'h01, 8'h03, 8'h01, 1'h0);
      t_roll(8'h23, 8'h30, 8'h04, 8'h05, 8'h00, 8'h01, 8'h05, 8'h05, 1'h0);
      test_done();
   end
   // hang guard well beyond the expected run
   initial begin
      repeat (90000) @(negedge clk);
      n_fail++;
      test_done();
   end
endmodule // tb_rtcs_top
`default_nettype wire
